// File: hdl/sefe_defs.svh
`ifndef SEFE_DEFS_SVH
`define SEFE_DEFS_SVH

`define SEFE_OP_SET_WL 8'h06
`define SEFE_OP_CLR_WL 8'h04
`define SEFE_OP_RD_STAT 8'h05
`define SEFE_OP_WR_STAT 8'h01
`define SEFE_OP_READ 8'h03
`define SEFE_OP_WRITE 8'h02

`define SEFE_SB_PPE 7
`define SEFE_SB_IPS 6
`define SEFE_SB_IPL 4
`define SEFE_SB_BPH 3
`define SEFE_SB_BPL 2

`define SEFE_RST_PPE 1'b0
`define SEFE_RST_IPL 1'b0
`define SEFE_RST_BP 2'h0

`define SEFE_ADDR_BITS 16
`define SEFE_PAGE_BITS 5
`define SEFE_FIFO_DEPTH 16
`define SEFE_SYNC_RST 5'h0B

`define SEFE_CLK_KHZ 40000
`define SEFE_WC_TIME_US 4000
`define SEFE_PU_TIME_US 350
`define SEFE_WC_CYCLES ((`SEFE_WC_TIME_US * `SEFE_CLK_KHZ) / 1000)
`define SEFE_PU_CYCLES ((`SEFE_PU_TIME_US * `SEFE_CLK_KHZ) / 1000)

`endif

// File: hdl/sefe_pkg.sv
`include "sefe_defs.svh"

package sefe_pkg;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_OPC = 3'b001,
      ST_ADDR = 3'b010,
      ST_WDATA = 3'b011,
      ST_SDATA = 3'b100,
      ST_OUT = 3'b101,
      ST_IGNORE = 3'b110
   } sefe_state_t;

   typedef struct packed {
      logic ident;
      logic [`SEFE_ADDR_BITS-1:0] addr;
      logic [7:0] data;
   } sefe_wr_t;
endpackage : sefe_pkg

// File: hdl/sefe_sync.sv
`timescale 1ns/1ps
`default_nettype none

module sefe_sync #(
   parameter int W = 5,
   parameter logic [W-1:0] RST = '0
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic clk_en,
   input wire logic [W-1:0] d_in,
   output logic [W-1:0] d_out
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;

   // a bit moves only when stages two and three agree, so one-cycle glitches never pass
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         s1_q <= RST;
         s2_q <= RST;
         s3_q <= RST;
         d_out <= RST;
      end else if (clk_en) begin
         s1_q <= d_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         d_out <= (s2_q & s3_q) | (d_out & (s2_q ^ s3_q));
      end
   end
endmodule : sefe_sync

`default_nettype wire

// File: hdl/sefe_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module sefe_fifo #(
   parameter int W = 25,
   parameter int DEPTH = 16
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic clk_en,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem_q [DEPTH];
   logic [AW:0] wr_q;
   logic [AW:0] rd_q;

   // depth must be a power of two; the extra pointer bit tells full from empty
   assign in_ready = (wr_q ^ rd_q) != {1'b1, {AW{1'b0}}};
   assign out_valid = wr_q != rd_q;
   assign out_data = mem_q[rd_q[AW-1:0]];

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         wr_q <= '0;
         rd_q <= '0;
      end else if (clk_en) begin
         if (in_valid && in_ready) begin
            wr_q <= wr_q + 1'b1;
         end
         if (out_valid && out_ready) begin
            rd_q <= rd_q + 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (clk_en && in_valid && in_ready) begin
         mem_q[wr_q[AW-1:0]] <= in_data;
      end
   end
endmodule : sefe_fifo

`default_nettype wire

// File: hdl/sefe_top.sv
// Contract
// - serial input bit is taken on each rising serial clock edge, both modes.
// - serial output moves to its next bit on each falling serial clock edge.
// - chip select high tri-states the output and idles, write cycle may continue.
// - protect pin high never blocks any write.
// - protect pin low with protect enable set refuses status updates.
// - a pause keeps the position in the current instruction sequence.
// - first eight bits after select falls form the opcode.
// - only the six defined opcodes act; any other opcode is ignored.
// - opcode 06h sets the write enable latch.
// - opcode 04h clears the write enable latch.
// - opcode 05h returns the status byte on the serial output.
// - opcode 01h loads the next byte into the writable status bits.
// - opcode 03h takes an address then returns stored bytes.
// - opcode 02h takes an address then bytes to program.
// - memory write acts only with the write enable latch set.
// - ident page select set steers reads and writes to the 32 byte page.
// - write cycle starts at select rising after a valid write, ends by 4 ms.
// - write enable latch is set and cleared by commands and shown in status.
// - during a write cycle only status read acts; busy shows in status.
// - hardware protection needs protect pin low and protect enable set.
// - ident page select clears itself after a read or write completes.
`include "sefe_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module sefe_top #(
   parameter int WC_CYCLES = `SEFE_WC_CYCLES,
   parameter int PU_CYCLES = `SEFE_PU_CYCLES,
   parameter int FIFO_DEPTH = `SEFE_FIFO_DEPTH
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic clk_en,
   input wire logic spi_sck,
   input wire logic spi_cs_n,
   input wire logic spi_si,
   input wire logic spi_hold_n,
   input wire logic spi_wp_n,
   output logic spi_so,
   output logic spi_so_oe,
   output logic mem_rd_req,
   output logic [`SEFE_ADDR_BITS-1:0] mem_rd_addr,
   output logic mem_rd_ident,
   input wire logic mem_rd_ack,
   input wire logic [7:0] mem_rd_data,
   output logic mem_wr_valid,
   input wire logic mem_wr_ready,
   output var sefe_pkg::sefe_wr_t mem_wr_word,
   output logic mem_wr_commit,
   output logic wr_overflow,
   output logic [7:0] status,
   output logic busy,
   output logic powered
);
   localparam int WCW = $clog2(WC_CYCLES + 1);
   localparam int PUW = $clog2(PU_CYCLES + 1);
   localparam int AB = `SEFE_ADDR_BITS;

   function automatic logic op_known(input logic [7:0] op);
      case (op)
         `SEFE_OP_SET_WL, `SEFE_OP_CLR_WL, `SEFE_OP_RD_STAT,
         `SEFE_OP_WR_STAT, `SEFE_OP_READ, `SEFE_OP_WRITE: op_known = 1'b1;
         default: op_known = 1'b0;
      endcase
   endfunction : op_known

   function automatic sefe_pkg::sefe_state_t op_state(input logic [7:0] op);
      case (op)
         `SEFE_OP_READ, `SEFE_OP_WRITE: op_state = sefe_pkg::ST_ADDR;
         `SEFE_OP_WR_STAT: op_state = sefe_pkg::ST_SDATA;
         `SEFE_OP_RD_STAT: op_state = sefe_pkg::ST_OUT;
         default: op_state = sefe_pkg::ST_IGNORE;
      endcase
   endfunction : op_state

   logic [4:0] pins_s;
   logic sck_s, cs_s, si_s, hold_s, wp_s;
   logic sck_prev_q, cs_prev_q;
   logic sck_rise, sck_fall, cs_rise, cs_fall;

   sefe_sync #(
      .W(5),
      .RST(`SEFE_SYNC_RST)
   ) u_sync (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .clk_en(clk_en),
      .d_in({spi_sck, spi_cs_n, spi_si, spi_hold_n, spi_wp_n}),
      .d_out(pins_s)
   );

   assign {sck_s, cs_s, si_s, hold_s, wp_s} = pins_s;

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         sck_prev_q <= 1'b0;
         cs_prev_q <= 1'b1;
      end else if (clk_en) begin
         sck_prev_q <= sck_s;
         cs_prev_q <= cs_s;
      end
   end

   // clock edges seen while paused are dropped, which freezes the bit, address and output counters
   assign sck_rise = hold_s && !cs_s && sck_s && !sck_prev_q;
   assign sck_fall = hold_s && !cs_s && !sck_s && sck_prev_q;
   assign cs_fall = !cs_s && cs_prev_q;
   assign cs_rise = cs_s && !cs_prev_q;

   sefe_pkg::sefe_state_t state_q;
   logic [2:0] bcnt_q;
   logic [7:0] rx_q, op_q, sdat_q;
   logic op_ok_q, sdat_ok_q, wbytes_q;
   logic [3:0] acnt_q;
   logic [AB-1:0] addr_q, rd_addr_q;
   logic rd_req_q, push_q;
   sefe_pkg::sefe_wr_t push_word_q;
   logic [7:0] rx_next;
   logic [AB-1:0] addr_next;
   logic [2:0] ocnt_q;
   logic busy_q, pwr_ok, wel_q, ppe_q, ips_q, ipl_q;
   logic [1:0] bp_q;
   logic wr_allowed, fifo_in_ready, wbyte_done;

   assign rx_next = {rx_q[6:0], si_s};
   assign addr_next = {addr_q[AB-2:0], si_s};
   assign wbyte_done = sck_rise && state_q == sefe_pkg::ST_WDATA && bcnt_q == 3'h7;
   // locked ident page, or ident page under full block protection, takes no write
   assign wr_allowed = wel_q && !(ips_q && (ipl_q || (&bp_q)));

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         state_q <= sefe_pkg::ST_IDLE;
         bcnt_q <= 3'h0;
         rx_q <= 8'h00;
         op_q <= 8'h00;
         op_ok_q <= 1'b0;
         sdat_q <= 8'h00;
         sdat_ok_q <= 1'b0;
         wbytes_q <= 1'b0;
         acnt_q <= 4'h0;
         addr_q <= '0;
         rd_addr_q <= '0;
         rd_req_q <= 1'b0;
         push_q <= 1'b0;
         push_word_q <= '0;
      end else if (clk_en) begin
         rd_req_q <= 1'b0;
         push_q <= 1'b0;
         if (cs_fall) begin
            state_q <= pwr_ok ? sefe_pkg::ST_OPC : sefe_pkg::ST_IGNORE;
            bcnt_q <= 3'h0;
            acnt_q <= 4'h0;
            op_ok_q <= 1'b0;
            sdat_ok_q <= 1'b0;
            wbytes_q <= 1'b0;
         end else if (cs_rise) begin
            state_q <= sefe_pkg::ST_IDLE;
         end else if (sck_rise) begin
            case (state_q)
               sefe_pkg::ST_OPC: begin
                  rx_q <= rx_next;
                  bcnt_q <= bcnt_q + 3'h1;
                  if (bcnt_q == 3'h7) begin
                     op_q <= rx_next;
                     if (busy_q && rx_next != `SEFE_OP_RD_STAT) begin
                        state_q <= sefe_pkg::ST_IGNORE;
                        op_ok_q <= 1'b0;
                     end else begin
                        state_q <= op_state(rx_next);
                        op_ok_q <= op_known(rx_next);
                     end
                  end
               end
               sefe_pkg::ST_ADDR: begin
                  acnt_q <= acnt_q + 4'h1;
                  addr_q <= addr_next;
                  if (acnt_q == 4'hF) begin
                     if (op_q == `SEFE_OP_READ) begin
                        state_q <= sefe_pkg::ST_OUT;
                        rd_req_q <= 1'b1;
                        rd_addr_q <= addr_next;
                        addr_q <= addr_next + 1'b1;
                     end else begin
                        state_q <= sefe_pkg::ST_WDATA;
                     end
                  end
               end
               sefe_pkg::ST_WDATA: begin
                  rx_q <= rx_next;
                  bcnt_q <= bcnt_q + 3'h1;
                  if (bcnt_q == 3'h7 && wr_allowed && fifo_in_ready) begin
                     push_q <= 1'b1;
                     push_word_q <= '{ident: ips_q, addr: addr_q, data: rx_next};
                     wbytes_q <= 1'b1;
                     // page offset wraps, the page number stays put
                     addr_q[`SEFE_PAGE_BITS-1:0] <= addr_q[`SEFE_PAGE_BITS-1:0] + 1'b1;
                  end
               end
               sefe_pkg::ST_SDATA: begin
                  rx_q <= rx_next;
                  bcnt_q <= bcnt_q + 3'h1;
                  if (bcnt_q == 3'h7) begin
                     sdat_q <= rx_next;
                     sdat_ok_q <= 1'b1;
                     state_q <= sefe_pkg::ST_IGNORE;
                  end
               end
               default: begin
               end
            endcase
         end else if (sck_fall && state_q == sefe_pkg::ST_OUT && ocnt_q == 3'h0
                      && op_q == `SEFE_OP_READ) begin
            rd_req_q <= 1'b1;
            rd_addr_q <= addr_q;
            addr_q <= addr_q + 1'b1;
         end
      end
   end

   logic [7:0] status_w, sh_q, tx_nxt_q, out_byte;
   logic so_q;

   assign status_w = {ppe_q, ips_q, 1'b0, ipl_q, bp_q, wel_q, busy_q};
   assign out_byte = (op_q == `SEFE_OP_RD_STAT) ? status_w : tx_nxt_q;

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         so_q <= 1'b0;
         sh_q <= 8'h00;
         ocnt_q <= 3'h0;
         tx_nxt_q <= 8'h00;
      end else if (clk_en) begin
         if (mem_rd_ack) begin
            tx_nxt_q <= mem_rd_data;
         end
         if (cs_fall) begin
            ocnt_q <= 3'h0;
         end else if (sck_fall && state_q == sefe_pkg::ST_OUT) begin
            ocnt_q <= ocnt_q + 3'h1;
            if (ocnt_q == 3'h0) begin
               so_q <= out_byte[7];
               sh_q <= {out_byte[6:0], 1'b0};
            end else begin
               so_q <= sh_q[7];
               sh_q <= {sh_q[6:0], 1'b0};
            end
         end
      end
   end

   assign spi_so = so_q;
   assign spi_so_oe = !cs_s && hold_s && state_q == sefe_pkg::ST_OUT;

   logic [WCW-1:0] wc_cnt_q;
   logic [PUW-1:0] pu_cnt_q;
   logic wc_mem_q, commit_q, wr_go, st_go, wc_end, hw_prot, both_locks;

   assign busy_q = wc_cnt_q != '0;
   assign wc_end = wc_cnt_q == WCW'(1);
   assign pwr_ok = pu_cnt_q == '0;
   assign hw_prot = !wp_s && ppe_q;
   assign wr_go = cs_rise && op_ok_q && op_q == `SEFE_OP_WRITE && wbytes_q && bcnt_q == 3'h0;
   assign st_go = cs_rise && op_ok_q && op_q == `SEFE_OP_WR_STAT && sdat_ok_q
                  && wel_q && !hw_prot;
   // setting both page bits in one status write leaves both untouched
   assign both_locks = sdat_q[`SEFE_SB_IPS] && sdat_q[`SEFE_SB_IPL];

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         pu_cnt_q <= PUW'(PU_CYCLES);
      end else if (clk_en && !pwr_ok) begin
         pu_cnt_q <= pu_cnt_q - 1'b1;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         wc_cnt_q <= '0;
         wc_mem_q <= 1'b0;
         commit_q <= 1'b0;
      end else if (clk_en) begin
         commit_q <= wr_go;
         if (wr_go || st_go) begin
            wc_cnt_q <= WCW'(WC_CYCLES);
            wc_mem_q <= wr_go;
         end else if (busy_q) begin
            wc_cnt_q <= wc_cnt_q - 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         wel_q <= 1'b0;
         ppe_q <= `SEFE_RST_PPE;
         ips_q <= 1'b0;
         ipl_q <= `SEFE_RST_IPL;
         bp_q <= `SEFE_RST_BP;
      end else if (clk_en) begin
         if (wc_end) begin
            wel_q <= 1'b0;
         end else if (cs_rise && op_ok_q && op_q == `SEFE_OP_SET_WL) begin
            wel_q <= 1'b1;
         end else if (cs_rise && op_ok_q && op_q == `SEFE_OP_CLR_WL) begin
            wel_q <= 1'b0;
         end
         if (st_go) begin
            ppe_q <= sdat_q[`SEFE_SB_PPE];
            bp_q <= {sdat_q[`SEFE_SB_BPH], sdat_q[`SEFE_SB_BPL]};
            if (!both_locks) begin
               ips_q <= sdat_q[`SEFE_SB_IPS];
               ipl_q <= ipl_q | sdat_q[`SEFE_SB_IPL];
            end
         end else if ((wc_end && wc_mem_q)
                      || (cs_rise && op_ok_q && op_q == `SEFE_OP_READ)) begin
            ips_q <= 1'b0;
         end
      end
   end

   logic drop_q;

   sefe_fifo #(
      .W($bits(sefe_pkg::sefe_wr_t)),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .clk_en(clk_en),
      .in_valid(push_q),
      .in_ready(fifo_in_ready),
      .in_data(push_word_q),
      .out_valid(mem_wr_valid),
      .out_ready(mem_wr_ready),
      .out_data(mem_wr_word)
   );

   // the host clock cannot be stalled, so a byte meeting a full queue is dropped and flagged
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         drop_q <= 1'b0;
      end else if (clk_en) begin
         if (wbyte_done && wr_allowed && !fifo_in_ready) begin
            drop_q <= 1'b1;
         end else if (cs_fall) begin
            drop_q <= 1'b0;
         end
      end
   end

   assign mem_rd_req = rd_req_q;
   assign mem_rd_addr = rd_addr_q;
   assign mem_rd_ident = ips_q;
   assign mem_wr_commit = commit_q;
   assign wr_overflow = drop_q;
   assign status = status_w;
   assign busy = busy_q;
   assign powered = pwr_ok;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!nrst || !clk_en);

   sequence seq_opc_done;
      sck_rise && state_q == sefe_pkg::ST_OPC && bcnt_q == 3'h7;
   endsequence

   sequence seq_wc_start;
      wr_go || st_go;
   endsequence

   AST_SI_SAMPLED: assert property (sck_rise && state_q == sefe_pkg::ST_OPC
      |=> rx_q[0] == $past(si_s))
      else $error("input bit not captured on rising clock");
   AST_SO_SHIFT: assert property (sck_fall && state_q == sefe_pkg::ST_OUT && ocnt_q != 3'h0
      |=> spi_so == $past(sh_q[7]))
      else $error("output bit not advanced on falling clock");
   AST_SO_HIZ: assert property (cs_s |-> !spi_so_oe)
      else $error("output driven with select high");
   AST_HOLD_HIZ: assert property (!hold_s |-> !spi_so_oe && !sck_rise && !sck_fall)
      else $error("activity while paused");
   AST_BAD_OP: assert property (seq_opc_done ##0 !op_known(rx_next) && !cs_fall
      |=> state_q == sefe_pkg::ST_IGNORE && !op_ok_q)
      else $error("unknown opcode not ignored");
   AST_BUSY_IGNORE: assert property (seq_opc_done ##0 busy_q && rx_next != `SEFE_OP_RD_STAT
      |=> !op_ok_q)
      else $error("command accepted during write cycle");
   AST_WEL_SET: assert property (cs_rise && op_ok_q && op_q == `SEFE_OP_SET_WL && !wc_end
      |=> wel_q && status[1])
      else $error("write enable latch not set");
   AST_WEL_CLR: assert property (cs_rise && op_ok_q && op_q == `SEFE_OP_CLR_WL |=> !wel_q)
      else $error("write enable latch not cleared");
   AST_STAT_PROT: assert property (cs_rise && hw_prot |=> $stable(ppe_q) && $stable(bp_q))
      else $error("status changed under hardware protection");
   AST_WC_START: assert property (seq_wc_start |=> busy_q [*8])
      else $error("write cycle did not start and hold");
   AST_WC_LEN: assert property (seq_wc_start |=> wc_cnt_q == WCW'(WC_CYCLES))
      else $error("write cycle length wrong");
   AST_NO_WEL_WRITE: assert property (wbyte_done && !wel_q |=> !push_q)
      else $error("byte queued without write enable");
endmodule : sefe_top

`default_nettype wire

// File: tb/sefe_host.sv
`timescale 1ns/1ps
`default_nettype none

module sefe_host (
   input wire logic clk_sys,
   input wire logic spi_so,
   output logic spi_sck,
   output logic spi_cs_n,
   output logic spi_si,
   output logic spi_hold_n
);
   logic cpol;
   logic [7:0] rx;

   initial begin
      cpol = 1'b0;
      spi_sck = 1'b0;
      spi_cs_n = 1'b1;
      spi_si = 1'b0;
      spi_hold_n = 1'b1;
      rx = 8'h00;
   end

   task automatic wait_clk(input int n);
      repeat (n) @(negedge clk_sys);
   endtask : wait_clk

   task automatic open_frame(input logic mode);
      cpol = mode;
      spi_sck = mode;
      wait_clk(4);
      spi_cs_n = 1'b0;
      wait_clk(4);
   endtask : open_frame

   // four system clocks per phase gives the 200 ns link period; the
   // returned bit is taken at the end of the high phase, well after it moved
   task automatic shift(input logic [7:0] tx, input int n);
      for (int i = 7; i > 7 - n; i--) begin
         spi_sck = 1'b0;
         spi_si = tx[i];
         wait_clk(4);
         spi_sck = 1'b1;
         wait_clk(4);
         rx = {rx[6:0], spi_so};
      end
   endtask : shift

   // sck is low at both pause-pin edges; the wiggles in between must be ignored
   task automatic hold_on();
      spi_sck = 1'b0;
      wait_clk(4);
      spi_hold_n = 1'b0;
      wait_clk(6);
      repeat (4) begin
         spi_sck = ~spi_sck;
         spi_si = ~spi_si;
         wait_clk(4);
      end
   endtask : hold_on

   task automatic hold_off();
      spi_hold_n = 1'b1;
      wait_clk(6);
   endtask : hold_off

   task automatic close_frame();
      spi_sck = cpol;
      wait_clk(4);
      spi_cs_n = 1'b1;
      spi_si = ~spi_si;
      wait_clk(8);
   endtask : close_frame
endmodule : sefe_host

`default_nettype wire

// File: tb/spi_eeprom_command_front_end_tb_top.sv
`include "sefe_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module spi_eeprom_command_front_end_tb_top;
   localparam int WC = 200;
   logic clk_sys = 1'b0;
   logic nrst, clk_en, spi_wp_n, mem_rd_ack, mem_wr_ready, so_line;
   logic spi_sck, spi_cs_n, spi_si, spi_hold_n, spi_so, spi_so_oe;
   logic mem_rd_req, mem_rd_ident, mem_wr_valid, mem_wr_commit, wr_overflow, busy, powered;
   logic [7:0] mem_rd_data, status, st;
   logic [`SEFE_ADDR_BITS-1:0] mem_rd_addr;
   sefe_pkg::sefe_wr_t mem_wr_word;
   sefe_pkg::sefe_wr_t words[$];
   logic [15:0] rd_addrs[$];
   int n_mismatch, comparisons, n_commit, n;

   always #12.5 clk_sys = ~clk_sys;
   // a released output line shows the inverse so a stale bit never passes
   assign so_line = spi_so_oe ? spi_so : ~spi_so;

   sefe_host host (.clk_sys(clk_sys), .spi_so(so_line), .spi_sck(spi_sck),
      .spi_cs_n(spi_cs_n), .spi_si(spi_si), .spi_hold_n(spi_hold_n));

   sefe_top #(.WC_CYCLES(WC), .PU_CYCLES(20)) u_dut (.clk_sys(clk_sys),
      .nrst(nrst), .clk_en(clk_en), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_si(spi_si),
      .spi_hold_n(spi_hold_n), .spi_wp_n(spi_wp_n), .spi_so(spi_so), .spi_so_oe(spi_so_oe),
      .mem_rd_req(mem_rd_req), .mem_rd_addr(mem_rd_addr), .mem_rd_ident(mem_rd_ident),
      .mem_rd_ack(mem_rd_ack), .mem_rd_data(mem_rd_data), .mem_wr_valid(mem_wr_valid),
      .mem_wr_ready(mem_wr_ready), .mem_wr_word(mem_wr_word), .mem_wr_commit(mem_wr_commit),
      .wr_overflow(wr_overflow), .status(status), .busy(busy), .powered(powered));

   // memory side answers one cycle after each request
   always @(negedge clk_sys) begin
      mem_rd_ack <= mem_rd_req;
      mem_rd_data <= mem_rd_addr[7:0] ^ 8'hA5;
      if (mem_rd_req) rd_addrs.push_back(mem_rd_addr);
      if (mem_wr_commit) n_commit++;
   end

   // pops are logged at the edge that takes them, so a ready raised at a falling edge never races
   always @(posedge clk_sys) begin
      if (mem_wr_valid && mem_wr_ready) words.push_back(mem_wr_word);
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic conclude();
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : conclude

   task automatic cmd(input logic [7:0] op);
      host.open_frame(1'b0);
      host.shift(op, 8);
      host.close_frame();
   endtask : cmd

   task automatic rd_status(input logic mode);
      host.open_frame(mode);
      host.shift(`SEFE_OP_RD_STAT, 8);
      host.shift(8'h00, 8);
      st = host.rx;
      host.close_frame();
   endtask : rd_status

   task automatic wr_status(input logic [7:0] v);
      cmd(`SEFE_OP_SET_WL);
      host.open_frame(1'b0);
      host.shift(`SEFE_OP_WR_STAT, 8);
      host.shift(v, 8);
      host.close_frame();
   endtask : wr_status

   task automatic wait_idle();
      n = 0;
      while (busy !== 1'b0 && n < 1000) begin
         @(negedge clk_sys);
         n++;
      end
      check("idle", busy, 1'b0);
   endtask : wait_idle

   initial begin
      repeat (20000) @(posedge clk_sys);
      n_mismatch++;
      conclude();
   end

   initial begin
      nrst = 1'b0;
      clk_en = 1'b1;
      spi_wp_n = 1'b1;
      mem_wr_ready = 1'b0;
      repeat (12) @(negedge clk_sys);
      nrst = 1'b1;
      for (int i = 0; i < 200 && powered !== 1'b1; i++) @(negedge clk_sys);
      check("powered", powered, 1'b1);
      rd_status(1'b0);
      check("status_reset", st, 8'h00);
      host.open_frame(1'b0);
      host.shift(8'hFF, 8);
      host.shift(8'h00, 8);
      check("oe_unknown_op", spi_so_oe, 1'b0);
      host.close_frame();
      cmd(`SEFE_OP_SET_WL);
      rd_status(1'b1);
      check("wel_set_mode3", st, 8'h02);
      cmd(`SEFE_OP_CLR_WL);
      rd_status(1'b0);
      check("wel_clear", st, 8'h00);
      wr_status(8'h84);
      check("busy_start", busy, 1'b1);
      // a frozen block must outlast a whole write cycle without finishing it
      clk_en = 1'b0;
      repeat (WC + 20) @(negedge clk_sys);
      check("frozen", busy, 1'b1);
      clk_en = 1'b1;
      cmd(`SEFE_OP_SET_WL);
      wait_idle();
      check("write_time", n < WC, 1'b1);
      check("status_written", status, 8'h84);
      spi_wp_n = 1'b0;
      wr_status(8'h00);
      wait_idle();
      check("status_guarded", status[7:2], 6'h21);
      spi_wp_n = 1'b1;
      wr_status(8'h40);
      wait_idle();
      check("status_wp_high", status, 8'h40);
      host.open_frame(1'b0);
      host.shift(`SEFE_OP_READ, 8);
      host.shift(8'h12, 8);
      host.shift(8'h34, 8);
      host.shift(8'h00, 8);
      check("read_b0", host.rx, 8'h91);
      check("read_ident", mem_rd_ident, 1'b1);
      host.shift(8'h00, 8);
      check("read_b1", host.rx, 8'h90);
      host.close_frame();
      check("read_addr", rd_addrs[0], 16'h1234);
      check("ident_cleared", status[6], 1'b0);
      check("oe_idle", spi_so_oe, 1'b0);
      host.open_frame(1'b0);
      host.shift(`SEFE_OP_WRITE, 8);
      host.shift(8'h00, 8);
      host.shift(8'h40, 8);
      host.shift(8'h5A, 8);
      host.close_frame();
      check("write_locked", mem_wr_valid, 1'b0);
      cmd(`SEFE_OP_SET_WL);
      host.open_frame(1'b0);
      host.shift(`SEFE_OP_WRITE, 8);
      host.shift(8'h00, 8);
      host.shift(8'h40, 8);
      for (int i = 0; i < 17; i++) host.shift(8'h10 + 8'(i), 8);
      host.close_frame();
      check("overflow", wr_overflow, 1'b1);
      mem_wr_ready = 1'b1;
      repeat (24) @(negedge clk_sys);
      check("queued", words.size(), 16);
      for (int i = 0; i < 16; i++) begin
         check("word", words[i], {1'b0, 16'h0040 + 16'(i), 8'h10 + 8'(i)});
      end
      check("commit", n_commit, 1);
      wait_idle();
      cmd(`SEFE_OP_SET_WL);
      host.open_frame(1'b0);
      host.shift(`SEFE_OP_RD_STAT, 8);
      host.shift(8'h00, 4);
      host.hold_on();
      check("oe_paused", spi_so_oe, 1'b0);
      host.hold_off();
      host.shift(8'h00, 4);
      check("read_resumed", host.rx, 8'h02);
      host.close_frame();
      // asking for both page bits at once leaves both as they were
      wr_status(8'h50);
      wait_idle();
      check("both_locks", status, 8'h00);
      conclude();
   end
endmodule : spi_eeprom_command_front_end_tb_top

`default_nettype wire
